// ===== verilog/csie_regs.sv
/*
 * Calibration status, interrupt enable, factory and test registers,
 * with the combined interrupt request.
 * Assumes an I2C target decodes bytes into one-cycle register strobes on
 * clk_sys; status flag inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
module csie_regs
    import csie_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire csie_reg_req_t reg_req,
    output logic [7:0] reg_rdata_q,
    output logic reg_rvalid_q,
    input wire logic auto_offset_lower_enable,
    input wire logic calibration_irq_flag,
    input wire csie_src_flags_t src_flags,
    input wire logic [15:0] prox_result,
    input wire logic prox_result_valid,
    input wire logic offset_load,
    input wire logic [7:0] offset_load_value,
    output logic [7:0] prox_offset_low_q,
    output logic offset_lowered_flag_q,
    output logic calibration_done_flag_q,
    output logic [7:0] test_setting_q,
    output logic irq_q
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic offset_lowered_flag_d;
    logic calibration_done_flag_d;
    logic [7:0] interrupt_enable_q;
    logic [7:0] interrupt_enable_d;
    logic [7:0] test_setting_d;
    logic [7:0] reg_rdata_d;
    logic reg_rvalid_d;
    logic irq_d;
    logic lowered_pulse;
    logic [7:0] status_view;
    logic [5:0] flag_vec;
    logic [5:0] en_vec;

    function automatic logic hit(input csie_reg_req_t r,
                                 input logic [7:0] a);
        hit = r.wr_en && (r.addr == a);
    endfunction

    // ----------------------------------------------------------------
    // Offset lowering engine
    // ----------------------------------------------------------------
    csie_offset_lower u_offset_lower (
        .clk_sys(clk_sys),
        .rst(rst),
        .auto_offset_lower_enable(auto_offset_lower_enable),
        .prox_result(prox_result),
        .prox_result_valid(prox_result_valid),
        .offset_load(offset_load),
        .offset_load_value(offset_load_value),
        .prox_offset_low_q(prox_offset_low_q),
        .lowered_pulse_q(lowered_pulse)
    );

    // ----------------------------------------------------------------
    // Register updates
    // ----------------------------------------------------------------
    always_comb begin
        offset_lowered_flag_d = offset_lowered_flag_q;
        if (!auto_offset_lower_enable) begin
            offset_lowered_flag_d = 1'b0; // RL2
        end else if (lowered_pulse) begin
            // Set wins over a same-cycle write-one clear
            offset_lowered_flag_d = 1'b1; // RL1
        end else if (hit(reg_req, CSIE_ADDR_CAL_STATUS)
                     && reg_req.wdata[CSIE_BIT_OFFSET_LOWERED]) begin
            offset_lowered_flag_d = 1'b0; // RL2
        end

        // Pure copy; cleared only by the main status register
        calibration_done_flag_d = calibration_irq_flag; // RL3

        interrupt_enable_d = interrupt_enable_q;
        if (hit(reg_req, CSIE_ADDR_INT_ENABLE)) begin
            // Reserved 1:0 held at zero whatever the host writes
            interrupt_enable_d = reg_req.wdata & CSIE_INT_ENABLE_MASK; // RL4
        end

        test_setting_d = test_setting_q;
        if (hit(reg_req, CSIE_ADDR_TEST_SET)) begin
            test_setting_d = reg_req.wdata; // RL9
        end
    end

    // ----------------------------------------------------------------
    // Read path and interrupt
    // ----------------------------------------------------------------
    always_comb begin
        status_view = 8'h00; // RL4
        status_view[CSIE_BIT_OFFSET_LOWERED] = offset_lowered_flag_q;
        status_view[CSIE_BIT_CAL_DONE] = calibration_done_flag_q;

        reg_rvalid_d = reg_req.rd_en;
        reg_rdata_d = CSIE_RST_READ_DATA;
        if (reg_req.rd_en) begin
            unique case (reg_req.addr)
                CSIE_ADDR_CAL_STATUS: reg_rdata_d = status_view;
                CSIE_ADDR_INT_ENABLE: reg_rdata_d = interrupt_enable_q;
                CSIE_ADDR_FACTORY_LO: reg_rdata_d = CSIE_FACTORY_LO_DEF; // RL8
                CSIE_ADDR_FACTORY_HI: reg_rdata_d = CSIE_FACTORY_HI_DEF; // RL8
                CSIE_ADDR_TEST_SET: reg_rdata_d = test_setting_q;
                default: reg_rdata_d = CSIE_RST_READ_DATA;
            endcase
        end

        flag_vec = {src_flags.light_sat, src_flags.prox_sat,
                    src_flags.prox_thr, src_flags.light_thr,
                    src_flags.cal, src_flags.zero_det};
        en_vec = {interrupt_enable_q[CSIE_BIT_LIGHT_SAT_EN], // RL5
                  interrupt_enable_q[CSIE_BIT_PROX_SAT_EN], // RL6
                  interrupt_enable_q[CSIE_BIT_PROX_THR_EN], // RL11
                  interrupt_enable_q[CSIE_BIT_LIGHT_THR_EN], // RL11
                  interrupt_enable_q[CSIE_BIT_CAL_EN], // RL11
                  interrupt_enable_q[CSIE_BIT_ZERO_EN]}; // RL7
        // Flags stay recorded upstream; enable only gates the output
        irq_d = |(flag_vec & en_vec); // RL12
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            offset_lowered_flag_q <= 1'b0;
            calibration_done_flag_q <= 1'b0;
            interrupt_enable_q <= CSIE_RST_INT_ENABLE;
            test_setting_q <= CSIE_RST_TEST_SET;
            reg_rdata_q <= CSIE_RST_READ_DATA;
            reg_rvalid_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            offset_lowered_flag_q <= offset_lowered_flag_d;
            calibration_done_flag_q <= calibration_done_flag_d;
            interrupt_enable_q <= interrupt_enable_d;
            test_setting_q <= test_setting_d;
            reg_rdata_q <= reg_rdata_d;
            reg_rvalid_q <= reg_rvalid_d;
            irq_q <= irq_d;
        end
    end

endmodule

// ===== verilog/csie_pkg.sv
/*
 * Package for the calibration status / interrupt enable register block:
 * register offsets, field positions, reset values and carrier types.
 * Assumes a register access port driven by the I2C target logic on clk_sys.
 */
// Notes on behaviour
// RL1 - The offset-lowered flag (status bit 2) sets on each offset decrement made while auto offset lowering is enabled.
// RL2 - The offset-lowered flag clears on a host write of one to bit 2 or when auto offset lowering is disabled; a zero write keeps it.
// RL3 - Status bit 0 always mirrors the calibration interrupt flag of the main status register and clears with it.
// RL4 - Reserved status bits 7:3 and 1 and enable bits 1:0 reset to zero and the host keeps them zero.
// RL5 - Enable bit 7 is a read/write, reset-zero enable for the light saturation interrupt.
// RL6 - Enable bit 6 is a read/write, reset-zero enable for the proximity saturation interrupt.
// RL7 - Enable bit 2 is a read/write, reset-zero enable for the zero-detect interrupt.
// RL8 - The two factory registers are read-only with factory contents and ignore writes.
// RL9 - The test register resets to 0x0c, is read/write, and the host sets it to 0x02 before use.
// RL10 - With auto offset lowering on, the low proximity offset decrements each time the proximity result becomes zero; the code holds it at zero.
// RL11 - Enable bits 5, 4 and 3 enable the proximity threshold, light threshold and calibration interrupts.
// RL12 - The interrupt output is high while any flag is set with its enable bit one.
package csie_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] CSIE_ADDR_CAL_STATUS = 8'hdc;
    localparam logic [7:0] CSIE_ADDR_INT_ENABLE = 8'hdd;
    localparam logic [7:0] CSIE_ADDR_FACTORY_LO = 8'he6;
    localparam logic [7:0] CSIE_ADDR_FACTORY_HI = 8'he7;
    localparam logic [7:0] CSIE_ADDR_TEST_SET = 8'hf9;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CSIE_BIT_OFFSET_LOWERED = 2;
    localparam int CSIE_BIT_CAL_DONE = 0;
    localparam int CSIE_BIT_LIGHT_SAT_EN = 7;
    localparam int CSIE_BIT_PROX_SAT_EN = 6;
    localparam int CSIE_BIT_PROX_THR_EN = 5;
    localparam int CSIE_BIT_LIGHT_THR_EN = 4;
    localparam int CSIE_BIT_CAL_EN = 3;
    localparam int CSIE_BIT_ZERO_EN = 2;

    // Writable bits of the enable register; 1:0 are reserved
    localparam logic [7:0] CSIE_INT_ENABLE_MASK = 8'hfc;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CSIE_RST_INT_ENABLE = 8'h00;
    localparam logic [7:0] CSIE_RST_TEST_SET = 8'h0c;
    localparam logic [7:0] CSIE_RST_PROX_OFFSET = 8'h00;
    localparam logic [7:0] CSIE_RST_READ_DATA = 8'h00;
    // Arbitrary neutral factory contents
    localparam logic [7:0] CSIE_FACTORY_LO_DEF = 8'h5a;
    localparam logic [7:0] CSIE_FACTORY_HI_DEF = 8'ha5;

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csie_reg_req_t;

    typedef struct packed {
        logic light_sat;
        logic prox_sat;
        logic prox_thr;
        logic light_thr;
        logic cal;
        logic zero_det;
    } csie_src_flags_t;

endpackage

// ===== verilog/csie_offset_lower.sv
/*
 * Automatic proximity offset lowering: decrements the low offset, never below
 * zero, each time the proximity result becomes zero while the feature is enabled.
 * Assumes the proximity result and offset load come from clk_sys logic.
 */
`timescale 1ns/1ps
module csie_offset_lower
    import csie_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic auto_offset_lower_enable,
    input wire logic [15:0] prox_result,
    input wire logic prox_result_valid,
    input wire logic offset_load,
    input wire logic [7:0] offset_load_value,
    output logic [7:0] prox_offset_low_q,
    output logic lowered_pulse_q
);

    logic was_zero_q;
    logic was_zero_d;
    logic [7:0] prox_offset_low_d;
    logic lowered_pulse_d;
    logic is_zero;

    always_comb begin
        is_zero = prox_result_valid && (prox_result == 16'h0000);
        was_zero_d = prox_result_valid ? is_zero : was_zero_q;
        prox_offset_low_d = prox_offset_low_q;
        lowered_pulse_d = 1'b0;
        if (offset_load) begin
            prox_offset_low_d = offset_load_value;
        end else if (auto_offset_lower_enable && is_zero && !was_zero_q
                     && prox_offset_low_q != 8'h00) begin
            // Only on entry to zero, and never wrap below zero
            prox_offset_low_d = prox_offset_low_q - 8'h01; // RL10
            lowered_pulse_d = 1'b1; // RL10
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            was_zero_q <= 1'b0;
            prox_offset_low_q <= CSIE_RST_PROX_OFFSET;
            lowered_pulse_q <= 1'b0;
        end else begin
            was_zero_q <= was_zero_d;
            prox_offset_low_q <= prox_offset_low_d;
            lowered_pulse_q <= lowered_pulse_d;
        end
    end

endmodule

// ===== dv/csie_host.sv
/* Host register master model for csie_regs.
   Assumes one-cycle strobes sampled on rising clk_sys. */
`timescale 1ns/1ps
module csie_host
    import csie_pkg::*;
(
    input wire logic clk_sys,
    output csie_reg_req_t req
);
    initial req = '0;
    // Reserved enable bits never sent as ones
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        req <= {1'b1, 1'b0, a,
            ((a == CSIE_ADDR_INT_ENABLE) ? d & CSIE_INT_ENABLE_MASK : d)};
        @(negedge clk_sys);
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk_sys);
        req <= {1'b0, 1'b1, a, 8'h00};
        @(negedge clk_sys);
        req <= '0;
    endtask
endmodule

// ===== dv/csie_regs_monitor.sv
/* Port checker for csie_regs.
   Bound onto csie_regs; sees only its ports. */
`timescale 1ns/1ps
module csie_regs_monitor
    import csie_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire csie_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata_q,
    input wire logic auto_offset_lower_enable,
    input wire logic calibration_irq_flag,
    input wire csie_src_flags_t src_flags,
    input wire logic offset_load,
    input wire logic [7:0] prox_offset_low_q,
    input wire logic offset_lowered_flag_q,
    input wire logic calibration_done_flag_q,
    input wire logic [7:0] test_setting_q,
    input wire logic irq_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic en;
    logic clr;
    assign en = auto_offset_lower_enable;
    assign clr = reg_req.wr_en && reg_req.addr == CSIE_ADDR_CAL_STATUS
        && reg_req.wdata[CSIE_BIT_OFFSET_LOWERED];
    property p_fac;
        reg_req.rd_en && reg_req.addr == CSIE_ADDR_FACTORY_LO
            |=> reg_rdata_q == CSIE_FACTORY_LO_DEF;
    endproperty
    a_fac: assert property (p_fac) else $error("factory byte");
    property p_cal;
        !$past(rst) |-> calibration_done_flag_q == $past(calibration_irq_flag);
    endproperty
    a_cal: assert property (p_cal) else $error("cal copy");
    property p_irq0;
        src_flags == '0 |=> !irq_q;
    endproperty
    a_irq0: assert property (p_irq0) else $error("irq idle");
    property p_trst;
        $fell(rst) |-> test_setting_q == CSIE_RST_TEST_SET;
    endproperty
    a_trst: assert property (p_trst) else $error("test reset");
    property p_twr;
        reg_req.wr_en && reg_req.addr == CSIE_ADDR_TEST_SET
            |=> test_setting_q == $past(reg_req.wdata);
    endproperty
    a_twr: assert property (p_twr) else $error("test write");
    property p_dis;
        !en |=> !offset_lowered_flag_q;
    endproperty
    a_dis: assert property (p_dis) else $error("flag disable");
    property p_hold;
        offset_lowered_flag_q && en && !clr |=> offset_lowered_flag_q;
    endproperty
    a_hold: assert property (p_hold) else $error("flag hold");
    property p_set;
        en && !$past(rst) && !$past(offset_load) &&
        prox_offset_low_q == $past(prox_offset_low_q) - 8'h01
            |=> offset_lowered_flag_q;
    endproperty
    a_set: assert property (p_set) else $error("flag set");
    property p_nodec;
        !en && !offset_load |=> $stable(prox_offset_low_q);
    endproperty
    a_nodec: assert property (p_nodec) else $error("offset moved");
    property p_rsv;
        reg_req.rd_en && reg_req.addr == CSIE_ADDR_INT_ENABLE
            |=> reg_rdata_q[1:0] == 2'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("enable reserved");
    c_flag: cover property (offset_lowered_flag_q);
    c_irq: cover property (irq_q);
    c_cal: cover property (calibration_done_flag_q);
endmodule
bind csie_regs csie_regs_monitor u_mon (.clk_sys, .rst, .reg_req,
    .reg_rdata_q, .auto_offset_lower_enable, .calibration_irq_flag,
    .src_flags, .offset_load, .prox_offset_low_q, .offset_lowered_flag_q,
    .calibration_done_flag_q, .test_setting_q, .irq_q);

// ===== dv/calib_status_int_enable_regs_test.sv
/* Self-checking bench for csie_regs.
   Host model drives registers; reads checked through a queue. */
`timescale 1ns/1ps
module calib_status_int_enable_regs_test import csie_pkg::*; ;
    logic clk_sys, rst, aen, cif, pv, ol, rv, flg, cdn, irq;
    logic [15:0] pr;
    logic [7:0] olv, rdt, poff, tst, rnd, en;
    csie_reg_req_t req;
    csie_src_flags_t sf;
    logic [7:0] exq[$];
    int fails, samples_checked, cyc;
    csie_host u_host (.clk_sys(clk_sys), .req(req));
    csie_regs u_dut (.clk_sys(clk_sys), .rst(rst), .reg_req(req),
        .reg_rdata_q(rdt), .reg_rvalid_q(rv), .auto_offset_lower_enable(aen),
        .calibration_irq_flag(cif), .src_flags(sf), .prox_result(pr),
        .prox_result_valid(pv), .offset_load(ol), .offset_load_value(olv),
        .prox_offset_low_q(poff), .offset_lowered_flag_q(flg),
        .calibration_done_flag_q(cdn), .test_setting_q(tst), .irq_q(irq));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exq.push_back(e);
        u_host.rd(a);
    endtask
    task automatic res(input logic [15:0] v);
        @(negedge clk_sys);
        pr = v;
        pv = 1;
        @(negedge clk_sys);
        pv = 0;
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        clk_sys = 0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (rv === 1'b1)
            chk("rdata", exq.pop_front(), rdt);
        if (cyc == 5000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        {rst, aen, cif, pv, ol, pr, olv, sf} = {5'h10, 16'h0, 8'h0, 6'h0};
        rnd = 8'h5e;
        repeat (12) @(negedge clk_sys);
        rst = 0;
        rd(CSIE_ADDR_CAL_STATUS, 8'h00);
        rd(CSIE_ADDR_TEST_SET, 8'h0c);
        rd(8'he0, 8'h00);
        u_host.wr(CSIE_ADDR_TEST_SET, 8'h02);
        chk("test_q", 8'h02, tst);
        rd(CSIE_ADDR_TEST_SET, 8'h02);
        rnd = lfsr(rnd);
        u_host.wr(CSIE_ADDR_FACTORY_LO, rnd);
        u_host.wr(CSIE_ADDR_FACTORY_HI, ~rnd);
        rd(CSIE_ADDR_FACTORY_LO, CSIE_FACTORY_LO_DEF);
        rd(CSIE_ADDR_FACTORY_HI, CSIE_FACTORY_HI_DEF);
        rd(CSIE_ADDR_INT_ENABLE, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            en = (8'(1 << (i + 2)) | rnd) & CSIE_INT_ENABLE_MASK;
            u_host.wr(CSIE_ADDR_INT_ENABLE, en | 8'(rnd[0]));
            rd(CSIE_ADDR_INT_ENABLE, en);
            sf = 6'(1 << i);
            repeat (2) @(negedge clk_sys);
            chk("irq_on", 8'h01, {7'h00, irq});
            u_host.wr(CSIE_ADDR_INT_ENABLE, en ^ 8'(1 << (i + 2)));
            @(negedge clk_sys);
            chk("irq_off", 8'h00, {7'h00, irq});
            sf = '0;
        end
        $display("test irq done");
        cif = 1;
        @(negedge clk_sys);
        chk("cal_copy", 8'h01, {7'h00, cdn});
        rd(CSIE_ADDR_CAL_STATUS, 8'h01);
        cif = 0;
        @(negedge clk_sys);
        chk("cal_clear", 8'h00, {7'h00, cdn});
        {ol, olv} = {1'b1, 8'h02};
        @(negedge clk_sys);
        {ol, aen} = 2'b01;
        res(16'h0005);
        res(16'h0000);
        res(16'h0000);
        @(negedge clk_sys);
        chk("offset", 8'h01, poff);
        rd(CSIE_ADDR_CAL_STATUS, 8'h04);
        u_host.wr(CSIE_ADDR_CAL_STATUS, 8'h00);
        rd(CSIE_ADDR_CAL_STATUS, 8'h04);
        u_host.wr(CSIE_ADDR_CAL_STATUS, 8'h04);
        rd(CSIE_ADDR_CAL_STATUS, 8'h00);
        for (int i = 0; i < 2; i++) begin
            res(16'h0009);
            res(16'h0000);
        end
        repeat (2) @(negedge clk_sys);
        chk("offset_floor", 8'h00, poff);
        chk("flag_set", 8'h01, {7'h00, flg});
        aen = 0;
        repeat (2) @(negedge clk_sys);
        chk("flag_off", 8'h00, {7'h00, flg});
        $display("test offset done");
        repeat (4) @(negedge clk_sys);
        end_sim();
    end
endmodule
